// ### crtc_port_pkg.sv
// Constants shared by the host port and display timing of the CRT controller.
// Assumes a single 200 MHz system clock and pins synchronised in the module.
package crtc_port_pkg;

    // Host data and index widths.
    localparam int          DATA_W      = 8;
    localparam int          IDX_W       = 5;
    localparam int          REG_COUNT   = 18;

    // Internal register numbers used by the timing logic.
    localparam logic [4:0]  REG_H_TOTAL = 5'h00;
    localparam logic [4:0]  REG_H_SHOWN = 5'h01;
    localparam logic [4:0]  REG_H_SYNC  = 5'h02;
    localparam logic [4:0]  REG_V_TOTAL = 5'h04;
    localparam logic [4:0]  REG_V_SHOWN = 5'h06;
    localparam logic [4:0]  REG_V_SYNC  = 5'h07;
    localparam logic [4:0]  REG_CUR_ROW = 5'h0E;
    localparam logic [4:0]  REG_CUR_COL = 5'h0F;

    // Status register field positions.
    localparam int          STAT_VBLANK = 5;
    localparam int          STAT_FRAME  = 6;

    // Reset values.
    localparam logic [7:0]  DATA_RST    = 8'h00;
    localparam logic [4:0]  IDX_RST     = 5'h00;
    localparam logic [7:0]  CNT_RST     = 8'h00;

endpackage : crtc_port_pkg

// ### crtc_host_port.sv
// Host port and reset behaviour of a raster-scan CRT timing controller.
// Assumes all pins are asynchronous to sys_clk and slow against 5 ns.
//
// Functional notes
// R1: Data bus drivers stay off except during a host read of the device.
// R2: Bus strobe gates the data buffers and times all register transfers.
// R3: Falling edge of the bus strobe is the active access edge.
// R4: Accesses are served only while device select is low.
// R5: Host asserts device select only for a stable decoded address.
// R6: Select low with a write stores data into the index register.
// R7: Select low with a read returns the status register.
// R8: Select high accesses the internal register named by the index.
// R9: Read-not-write low writes, high reads.
// R10: Counter clear zeroes counters, halts display, drives outputs low.
// R11: Counter clear leaves programmed control registers unchanged.
// R12: Counter clear acts only while pen strobe is also low.
// R13: Display timing restarts at once when counter clear returns high.
// R14: Visible area and cursor stay off until one full frame is scanned.
// R15: Display timing advances on the separate character clock only.
`timescale 1ns/1ps
module crtc_host_port
    import crtc_port_pkg::*;
(
    input  wire logic              sys_clk,          // System clock.
    input  wire logic              rst_b,            // Sync reset, low.
    input  wire logic [DATA_W-1:0] host_data_in,     // Data bus from pins.
    output logic      [DATA_W-1:0] host_data_out,    // Data bus to pins.
    output logic                   host_data_oe,     // High drives bus.
    input  wire logic              dev_sel_n,        // Device select, low.
    input  wire logic              index_or_data_sel, // Low index, high data.
    input  wire logic              read_not_write,   // High read, low write.
    input  wire logic              bus_strobe,       // Host enable strobe.
    input  wire logic              counter_clear_n,  // Counter clear, low.
    input  wire logic              pen_strobe,       // Pen strobe input.
    input  wire logic              char_clk,         // Character clock pin.
    output logic                   visible_area_flag, // Visible area out.
    output logic                   cursor_out,       // Cursor out.
    output logic                   hsync_out,        // Horizontal sync.
    output logic                   vsync_out         // Vertical sync.
);

    // Two-stage synchronisers for every pin input.
    // Reset loads zeros, so select reads as asserted for two cycles; no
    // access can start then, because the strobe history is low as well.
    localparam int PIN_W = DATA_W + 7;
    logic [PIN_W-1:0] pin_raw;
    logic [PIN_W-1:0] pin_meta_q;
    logic [PIN_W-1:0] pin_sync_q;

    assign pin_raw = {host_data_in, dev_sel_n, index_or_data_sel,
                      read_not_write, bus_strobe, counter_clear_n,
                      pen_strobe, char_clk};

    // Each pin bit passes two flip-flops before any logic reads it.
    genvar gi;
    generate
        for (gi = 0; gi < PIN_W; gi++) begin : g_sync
            always_ff @(posedge sys_clk) begin
                if (!rst_b) begin
                    pin_meta_q[gi] <= 1'b0;
                    pin_sync_q[gi] <= 1'b0;
                end else begin
                    pin_meta_q[gi] <= pin_raw[gi];
                    pin_sync_q[gi] <= pin_meta_q[gi];
                end
            end
        end
    endgenerate

    logic [DATA_W-1:0] data_s;
    logic              sel_n_s;
    logic              rs_s;
    logic              rnw_s;
    logic              strobe_s;
    logic              clear_n_s;
    logic              pen_s;
    logic              cclk_s;

    assign data_s    = pin_sync_q[PIN_W-1:7];
    assign sel_n_s   = pin_sync_q[6];
    assign rs_s      = pin_sync_q[5];
    assign rnw_s     = pin_sync_q[4];
    assign strobe_s  = pin_sync_q[3];
    assign clear_n_s = pin_sync_q[2];
    assign pen_s     = pin_sync_q[1];
    assign cclk_s    = pin_sync_q[0];

    // Edge detection on the synchronised strobe and character clock.
    logic strobe_d1_q;
    logic cclk_d1_q;

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            strobe_d1_q <= 1'b0;
            cclk_d1_q   <= 1'b0;
        end else begin
            strobe_d1_q <= strobe_s;
            cclk_d1_q   <= cclk_s;
        end
    end

    logic access_edge;
    logic char_tick;
    logic clear_act;

    assign access_edge = strobe_d1_q && !strobe_s && !sel_n_s; // see R3 R4
    assign char_tick   = cclk_s && !cclk_d1_q;                 // see R15
    assign clear_act   = !clear_n_s && !pen_s;                 // see R12

    // Index register and internal register file; system reset only.
    logic [IDX_W-1:0]  index_q;
    logic [DATA_W-1:0] regs_q [REG_COUNT];

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            index_q <= IDX_RST;
        end else if (access_edge && !rnw_s && !rs_s) begin // see R6 R9
            index_q <= data_s[IDX_W-1:0];
        end
    end

    // Register file writes; counter clear does not touch it.
    // Only the system reset clears the file, so clear_act never reaches it.
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin                               // see R11
            for (int i = 0; i < REG_COUNT; i++) begin
                regs_q[i] <= DATA_RST;
            end
        end else if (access_edge && !rnw_s && rs_s                // see R8
                     && (int'(index_q) < REG_COUNT)) begin
            regs_q[index_q] <= data_s;
        end
    end

    // Display counters and frame tracking.
    logic [DATA_W-1:0] h_cnt_q;
    logic [DATA_W-1:0] v_cnt_q;
    logic              frame_done_q;
    logic              line_end;
    logic              frame_end;

    assign line_end  = (h_cnt_q >= regs_q[REG_H_TOTAL]);
    assign frame_end = line_end && (v_cnt_q >= regs_q[REG_V_TOTAL]);

    // Counters clear and halt under counter clear, run again at release.
    always_ff @(posedge sys_clk) begin
        if (!rst_b || clear_act) begin                  // see R10
            h_cnt_q <= CNT_RST;
            v_cnt_q <= CNT_RST;
        end else if (char_tick) begin                   // see R13 R15
            if (line_end) begin
                h_cnt_q <= CNT_RST;
                v_cnt_q <= frame_end ? CNT_RST : v_cnt_q + 8'h01;
            end else begin
                h_cnt_q <= h_cnt_q + 8'h01;
            end
        end
    end

    // The first complete frame after release is scanned dark.
    always_ff @(posedge sys_clk) begin
        if (!rst_b || clear_act) begin
            frame_done_q <= 1'b0;
        end else if (char_tick && frame_end) begin      // see R14
            frame_done_q <= 1'b1;
        end
    end

    // Display outputs, all low while counters are cleared.
    logic in_h;
    logic in_v;

    assign in_h = (h_cnt_q < regs_q[REG_H_SHOWN]);
    assign in_v = (v_cnt_q < regs_q[REG_V_SHOWN]);

    always_ff @(posedge sys_clk) begin
        if (!rst_b || clear_act) begin                  // see R10
            visible_area_flag <= 1'b0;
            cursor_out        <= 1'b0;
            hsync_out         <= 1'b0;
            vsync_out         <= 1'b0;
        end else begin
            visible_area_flag <= frame_done_q && in_h && in_v; // see R14
            cursor_out        <= frame_done_q                  // see R14
                                 && (h_cnt_q == regs_q[REG_CUR_COL])
                                 && (v_cnt_q == regs_q[REG_CUR_ROW]);
            hsync_out         <= (h_cnt_q == regs_q[REG_H_SYNC]);
            vsync_out         <= (v_cnt_q == regs_q[REG_V_SYNC]);
        end
    end

    // Status value seen on an index-side read.
    logic [DATA_W-1:0] status_val;
    logic [DATA_W-1:0] read_val;

    always_comb begin
        status_val              = DATA_RST;
        status_val[STAT_VBLANK] = !in_v;
        status_val[STAT_FRAME]  = frame_done_q;
        if (!rs_s) begin                                // see R7
            read_val = status_val;
        end else if (int'(index_q) < REG_COUNT) begin   // see R8
            read_val = regs_q[index_q];
        end else begin
            read_val = DATA_RST;
        end
    end

    // Bus drive only while strobe is high on a selected read.
    // Read data follows the live selection; only the enable waits on it.
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            host_data_oe  <= 1'b0;
            host_data_out <= DATA_RST;
        end else begin
            host_data_oe  <= strobe_s && !sel_n_s && rnw_s; // see R1 R2 R9
            host_data_out <= read_val;                      // see R2
        end
    end

endmodule : crtc_host_port

// ### crtc_host_port_monitor.sv
// Checker for the host port and counter clear of the CRT controller.
// Assumes three sys_clk edges of pin synchroniser delay.
`timescale 1ns/1ps
module crtc_host_port_monitor
    import crtc_port_pkg::*;
(
    input wire logic sys_clk,           // System clock.
    input wire logic rst_b,             // Sync reset, low.
    input wire logic host_data_oe,      // Bus drive enable.
    input wire logic dev_sel_n,         // Device select, low.
    input wire logic read_not_write,    // High read.
    input wire logic bus_strobe,        // Host strobe.
    input wire logic counter_clear_n,   // Counter clear, low.
    input wire logic pen_strobe,        // Pen strobe.
    input wire logic visible_area_flag, // Visible area.
    input wire logic cursor_out,        // Cursor.
    input wire logic hsync_out,         // Horizontal sync.
    input wire logic vsync_out          // Vertical sync.
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    // The bus is driven only for a selected read with the strobe high.
    drive_read_a: assert property (
        host_data_oe |-> $past(read_not_write, 3))
        else $error("bus driven outside a read");
    drive_sel_a: assert property (
        host_data_oe |-> !$past(dev_sel_n, 3))
        else $error("bus driven while not selected");
    drive_strobe_a: assert property (
        host_data_oe |-> $past(bus_strobe, 3))
        else $error("bus driven with strobe low");
    strobe_fall_a: assert property (
        $fell(bus_strobe) |-> ##[1:4] !host_data_oe)
        else $error("drive kept after strobe fall");
    read_drive_a: assert property (
        (!dev_sel_n && read_not_write && bus_strobe)[*5] |-> host_data_oe)
        else $error("selected read not driven");
    // Reset quietens every output whatever the clear pins do.
    reset_quiet_a: assert property (
        disable iff (1'b0) !rst_b |=>
        !(host_data_oe | visible_area_flag | cursor_out | hsync_out
          | vsync_out))
        else $error("output high after reset");
    clear_quiet_a: assert property (
        (!counter_clear_n && !pen_strobe)[*6]
        |-> !(visible_area_flag | cursor_out | hsync_out | vsync_out))
        else $error("display output high during clear");
    first_frame_a: assert property (
        (!counter_clear_n && !pen_strobe)[*6] ##1 counter_clear_n
        |-> (!visible_area_flag && !cursor_out)[*8])
        else $error("visible area before a full frame");
endmodule : crtc_host_port_monitor

bind crtc_host_port crtc_host_port_monitor mon (
    .sys_clk           (sys_clk),
    .rst_b             (rst_b),
    .host_data_oe      (host_data_oe),
    .dev_sel_n         (dev_sel_n),
    .read_not_write    (read_not_write),
    .bus_strobe        (bus_strobe),
    .counter_clear_n   (counter_clear_n),
    .pen_strobe        (pen_strobe),
    .visible_area_flag (visible_area_flag),
    .cursor_out        (cursor_out),
    .hsync_out         (hsync_out),
    .vsync_out         (vsync_out)
);

// ### host_bus_model.sv
// Host processor bus model driving one register access at a time.
// Assumes the bench resolves the data bus level into host_data_in.
`timescale 1ns/1ps
module host_bus_model (
    input wire logic       sys_clk,           // System clock.
    input wire logic [7:0] host_data_in,      // Resolved bus level.
    output logic           dev_sel_n,         // Device select, low.
    output logic           index_or_data_sel, // Low index, high data.
    output logic           read_not_write,    // High read.
    output logic           bus_strobe,        // Enable strobe.
    output logic [7:0]     hd,                // Host write data.
    output logic           drv                // High while host drives.
);
    // Idle bus: deselected, strobe low, host not driving.
    initial begin
        {dev_sel_n, index_or_data_sel, read_not_write} <= 3'h4;
        {bus_strobe, drv, hd}                          <= 10'h000;
    end
    // Select, address and direction stay fixed for the whole strobe.
    task automatic acc(input logic s, r, w, input logic [7:0] d,
                       output logic [7:0] q);
        @(posedge sys_clk);
        dev_sel_n <= s;
        index_or_data_sel <= r;
        read_not_write <= w;
        hd <= d;
        drv <= !w;
        bus_strobe <= 1'b1;
        repeat (6) @(posedge sys_clk);
        q = host_data_in;
        bus_strobe <= 1'b0;
        repeat (6) @(posedge sys_clk);
        dev_sel_n <= 1'b1;
        drv <= 1'b0;
    endtask : acc
endmodule : host_bus_model

// ### tb_crtc_host_port.sv
// Self-checking bench for the CRT controller host port.
// Assumes the host bus model and the bound checker beside it.
`timescale 1ns/1ps
module tb_crtc_host_port
    import crtc_port_pkg::*;
;
    typedef struct packed {logic [4:0] idx; logic [7:0] wr, ex;} row_t;
    logic sys_clk = 0, rst_b = 0, counter_clear_n = 0, pen_strobe = 0;
    logic host_data_oe, visible_area_flag, cursor_out, hsync_out, vsync_out;
    logic dev_sel_n, index_or_data_sel, read_not_write, bus_strobe, drv;
    logic [7:0] host_data_out, hd, host_data_in, q;
    logic [1:0] cdiv = 2'h0;
    logic char_clk;
    int err_count = 0, check_count = 0, i;
    row_t rows [9] = '{'{5'h00, 8'h03, 8'h03}, '{5'h01, 8'h02, 8'h02},
        '{5'h02, 8'h01, 8'h01}, '{5'h04, 8'h02, 8'h02},
        '{5'h06, 8'h01, 8'h01}, '{5'h07, 8'h01, 8'h01},
        '{5'h11, 8'ha5, 8'ha5}, '{5'h12, 8'h3c, 8'h00},
        '{5'h1f, 8'hff, 8'h00}};
    // Clock, character clock and bus level; a released bus reads inverted.
    always #2.5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) cdiv <= cdiv + 2'h1;
    assign char_clk = cdiv[1];
    assign host_data_in = host_data_oe ? host_data_out : (drv ? hd : ~hd);
    crtc_host_port dut (
        .sys_clk           (sys_clk),
        .rst_b             (rst_b),
        .host_data_in      (host_data_in),
        .host_data_out     (host_data_out),
        .host_data_oe      (host_data_oe),
        .dev_sel_n         (dev_sel_n),
        .index_or_data_sel (index_or_data_sel),
        .read_not_write    (read_not_write),
        .bus_strobe        (bus_strobe),
        .counter_clear_n   (counter_clear_n),
        .pen_strobe        (pen_strobe),
        .char_clk          (char_clk),
        .visible_area_flag (visible_area_flag),
        .cursor_out        (cursor_out),
        .hsync_out         (hsync_out),
        .vsync_out         (vsync_out)
    );
    host_bus_model m (
        .sys_clk           (sys_clk),
        .host_data_in      (host_data_in),
        .dev_sel_n         (dev_sel_n),
        .index_or_data_sel (index_or_data_sel),
        .read_not_write    (read_not_write),
        .bus_strobe        (bus_strobe),
        .hd                (hd),
        .drv               (drv)
    );
    // Compares one value against its expectation.
    task automatic check(input logic [7:0] seen, exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    // Waits a bounded time for a flag to rise.
    task automatic wait_hi(ref logic s);
        for (i = 0; i < 400 && s !== 1'b1; i++) @(posedge sys_clk);
        check({7'h0, s}, 8'h01);
    endtask : wait_hi
    // Prints the counts and the verdict, then ends the run.
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : print_verdict
    // Main sequence: table of register accesses, then the awkward cases.
    initial begin
        repeat (6) @(posedge sys_clk);
        rst_b <= 1'b1;
        repeat (5) @(posedge sys_clk);
        m.acc(0, 0, 1, 8'h00, q);
        check(q & 8'h40, 8'h00);
        foreach (rows[k]) begin
            m.acc(0, 0, 0, {3'h0, rows[k].idx}, q);
            m.acc(0, 1, 0, rows[k].wr, q);
            m.acc(0, 1, 1, 8'h00, q);
            check(q, rows[k].ex);
        end
        m.acc(0, 0, 0, 8'h11, q);
        m.acc(1, 1, 0, 8'h77, q);
        m.acc(0, 1, 1, 8'h00, q);
        check(q, 8'ha5);
        pen_strobe <= 1'b1;
        wait_hi(hsync_out);
        pen_strobe <= 1'b0;
        repeat (20) @(posedge sys_clk);
        check({7'h0, hsync_out | vsync_out}, 8'h00);
        counter_clear_n <= 1'b1;
        wait_hi(hsync_out);
        check({7'h0, visible_area_flag}, 8'h00);
        wait_hi(visible_area_flag);
        check({7'h0, cursor_out}, 8'h01);
        m.acc(0, 1, 1, 8'h00, q);
        check(q, 8'ha5);
        print_verdict();
    end
endmodule : tb_crtc_host_port
